//--- rtl/svw_pkg.sv
// Functional notes
// - Watchdog disarmed after power-up, power-on reset, watchdog timeout and manual reset.
// - Only a falling strobe edge after power-on reset arms the watchdog.
// - While armed any strobe edge restarts timeout; expiry drives reset active.
// - No watchdog reset when edges come closer than the option's minimum period.
// - Always reset when no edge arrives within the option's maximum period.
// - Four selectable timeouts: 6.3 ms, 102 ms, 1.6 s, 25.6 s.
// - Default timeout selection is the 1.6 s option.
// - Strobe pull-up enabled while disarmed.
// - Arming drops the pull-up until power-on, reset event or timeout.
// - Any reset assertion holds reset active for the full hold period.
// - Reset hold period defaults to 200 ms, other options selectable.
// - Manual reset low for the assertion delay forces reset and disarms.
// - At power-up reset holds, hold timer starts once supply is good.
package svw_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned PS_PER_US = 1000000;
  // Timeout windows in microseconds: minimum and maximum per option
  localparam longint unsigned WD_MIN_US [4] = '{4300, 71000, 1120000, 17900000};
  localparam longint unsigned WD_MAX_US [4] = '{9300, 153000, 2400000, 38400000};
  // Design aims between min and max: nominal period
  localparam longint unsigned WD_NOM_US [4] = '{6300, 102000, 1600000, 25600000};
  localparam longint unsigned HOLD_NOM_US [4] = '{1400, 30000, 200000, 1600000};
  localparam logic [1:0] WD_SEL_DEFAULT = 2'h2;
  localparam logic [1:0] HOLD_SEL_DEFAULT = 2'h2;
  localparam longint unsigned MRD_US = 1;
  localparam int unsigned CNT_W = 32;
  function automatic logic [CNT_W-1:0] us_to_cycles(input longint unsigned us);
    longint unsigned c;
    c = (us * PS_PER_US) / CLK_PERIOD_PS;
    if (c < 1) c = 1;
    return c[CNT_W-1:0];
  endfunction
  typedef enum logic [1:0] {SVW_POWERUP, SVW_HOLD, SVW_RUN} svw_state_t;
endpackage

//--- rtl/svw_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser with edge report from the second and third stages
module svw_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic level,
  output logic edge_any,
  output logic edge_fall
);
  logic meta;
  logic stable;
  logic prev;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= INIT;
      stable <= INIT;
      prev <= INIT;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end
  assign level = stable;
  assign edge_any = stable ^ prev;
  assign edge_fall = prev & ~stable;
endmodule
`default_nettype wire

//--- rtl/svw_top.sv
`timescale 1ns/100ps
`default_nettype none
module svw_top #(
  parameter logic RST_ACTIVE_HIGH = 1'b0,
  parameter logic [svw_pkg::CNT_W-1:0] WD_CYC_0 = svw_pkg::us_to_cycles(svw_pkg::WD_NOM_US[0]),
  parameter logic [svw_pkg::CNT_W-1:0] WD_CYC_1 = svw_pkg::us_to_cycles(svw_pkg::WD_NOM_US[1]),
  parameter logic [svw_pkg::CNT_W-1:0] WD_CYC_2 = svw_pkg::us_to_cycles(svw_pkg::WD_NOM_US[2]),
  parameter logic [svw_pkg::CNT_W-1:0] WD_CYC_3 = svw_pkg::us_to_cycles(svw_pkg::WD_NOM_US[3]),
  parameter logic [svw_pkg::CNT_W-1:0] HOLD_CYC_0 = svw_pkg::us_to_cycles(svw_pkg::HOLD_NOM_US[0]),
  parameter logic [svw_pkg::CNT_W-1:0] HOLD_CYC_1 = svw_pkg::us_to_cycles(svw_pkg::HOLD_NOM_US[1]),
  parameter logic [svw_pkg::CNT_W-1:0] HOLD_CYC_2 = svw_pkg::us_to_cycles(svw_pkg::HOLD_NOM_US[2]),
  parameter logic [svw_pkg::CNT_W-1:0] HOLD_CYC_3 = svw_pkg::us_to_cycles(svw_pkg::HOLD_NOM_US[3]),
  parameter logic [svw_pkg::CNT_W-1:0] MRD_CYC = svw_pkg::us_to_cycles(svw_pkg::MRD_US)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic supply_good,
  input wire logic watchdog_strobe_in,
  input wire logic manual_reset_in_n,
  input wire logic [1:0] timeout_sel,
  input wire logic [1:0] hold_sel,
  output logic reset_out,
  output logic reset_out_comp,
  output logic strobe_pullup_en,
  output logic armed
);
  initial begin
    if (WD_CYC_0 < 2 || WD_CYC_1 < 2 || WD_CYC_2 < 2 || WD_CYC_3 < 2)
      $error("Watchdog period too short");
    if (HOLD_CYC_0 < 1 || HOLD_CYC_1 < 1 || HOLD_CYC_2 < 1 || HOLD_CYC_3 < 1 || MRD_CYC < 1)
      $error("Hold or manual delay count zero");
  end

  localparam logic [svw_pkg::CNT_W-1:0] ONE = 32'h0000_0001;

  logic sup_q1;
  logic sup_ok;
  logic strobe_lvl;
  logic strobe_edge;
  logic strobe_fall;
  logic mr_lvl;
  svw_pkg::svw_state_t state;
  svw_pkg::svw_state_t next_state;
  logic [svw_pkg::CNT_W-1:0] hold_cnt;
  logic [svw_pkg::CNT_W-1:0] wd_cnt;
  logic [svw_pkg::CNT_W-1:0] mr_cnt;
  logic por_done;
  logic rst_active;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sup_q1 <= 1'b0;
      sup_ok <= 1'b0;
    end else begin
      sup_q1 <= supply_good;
      sup_ok <= sup_q1;
    end
  end

  svw_sync #(.INIT(1'b1)) u_strobe (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(watchdog_strobe_in),
    .level(strobe_lvl),
    .edge_any(strobe_edge),
    .edge_fall(strobe_fall)
  );

  svw_sync #(.INIT(1'b1)) u_mr (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(manual_reset_in_n),
    .level(mr_lvl),
    .edge_any(),
    .edge_fall()
  );

  wire [svw_pkg::CNT_W-1:0] wd_limit = (timeout_sel == 2'h0) ? WD_CYC_0 :
                                        (timeout_sel == 2'h1) ? WD_CYC_1 :
                                        (timeout_sel == 2'h2) ? WD_CYC_2 : WD_CYC_3;
  wire [svw_pkg::CNT_W-1:0] hold_limit = (hold_sel == 2'h0) ? HOLD_CYC_0 :
                                          (hold_sel == 2'h1) ? HOLD_CYC_1 :
                                          (hold_sel == 2'h2) ? HOLD_CYC_2 : HOLD_CYC_3;
  wire mr_fire = (mr_cnt == MRD_CYC - ONE) && !mr_lvl;
  wire wd_fire = armed && !strobe_edge && (wd_cnt == wd_limit - ONE);
  wire hold_done = (state == svw_pkg::SVW_HOLD) && (hold_cnt == hold_limit - ONE);
  wire arm_now = (state == svw_pkg::SVW_RUN) && !armed && por_done && strobe_fall;
  wire supply_lost = !sup_ok;
  // Pull-up follows the arm state of the same edge, so it never lags a disarm
  wire next_armed = (state == svw_pkg::SVW_RUN) && !wd_fire && !mr_fire && (armed || arm_now);

  always_comb begin
    next_state = state;
    case (state)
      svw_pkg::SVW_POWERUP: if (sup_ok) next_state = svw_pkg::SVW_HOLD;
      svw_pkg::SVW_HOLD: begin
        if (supply_lost) next_state = svw_pkg::SVW_POWERUP;
        else if (hold_done) next_state = svw_pkg::SVW_RUN;
      end
      svw_pkg::SVW_RUN: begin
        if (supply_lost) next_state = svw_pkg::SVW_POWERUP;
        else if (wd_fire || mr_fire) next_state = svw_pkg::SVW_HOLD;
      end
      default: next_state = svw_pkg::SVW_POWERUP;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) state <= svw_pkg::SVW_POWERUP;
    else state <= next_state;
  end

  // Hold counter restarts whenever the hold state is entered afresh
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state != svw_pkg::SVW_HOLD) hold_cnt <= '0;
    else if (!hold_done) hold_cnt <= hold_cnt + ONE;
  end

  // Manual reset filter; also doubles as the glitch filter on the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst || mr_lvl || state != svw_pkg::SVW_RUN) mr_cnt <= '0;
    else if (!mr_fire) mr_cnt <= mr_cnt + ONE;
  end

  // Arming needs the first release of power-on reset; later resets leave it set
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state == svw_pkg::SVW_POWERUP) por_done <= 1'b0;
    else if (state == svw_pkg::SVW_RUN) por_done <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) armed <= 1'b0;
    else armed <= next_armed;
  end

  // Nominal count lies inside min..max of every option
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !armed || strobe_edge) wd_cnt <= '0;
    else if (!wd_fire) wd_cnt <= wd_cnt + ONE;
  end

  assign rst_active = (state != svw_pkg::SVW_RUN);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_out <= RST_ACTIVE_HIGH;
      reset_out_comp <= ~RST_ACTIVE_HIGH;
      strobe_pullup_en <= 1'b1;
    end else begin
      reset_out <= rst_active ~^ RST_ACTIVE_HIGH ? 1'b1 : 1'b0;
      reset_out_comp <= rst_active ~^ RST_ACTIVE_HIGH ? 1'b0 : 1'b1;
      strobe_pullup_en <= !next_armed;
    end
  end

  sequence s_armed_quiet;
    armed && !strobe_edge;
  endsequence

  a_arm_only_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(armed) |-> $past(strobe_fall)) else $error("Armed without falling strobe edge");
  a_edge_restarts: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (armed && strobe_edge) |=> (wd_cnt == '0)) else $error("Edge did not restart timeout");
  a_timeout_resets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_armed_quiet and wd_cnt == wd_limit - ONE) |=> (state == svw_pkg::SVW_HOLD && !armed))
    else $error("Timeout did not force reset");
  // Limit is the nominal count, which lies above the minimum of every option
  a_no_early_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (armed && (wd_cnt + ONE < wd_limit) && !mr_fire && sup_ok)
    |=> state == svw_pkg::SVW_RUN) else $error("Watchdog reset before minimum");
  a_disarm_in_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state != svw_pkg::SVW_RUN) |=> !armed) else $error("Armed during reset");
  a_pullup_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (strobe_pullup_en == !armed)) else $error("Pull-up not tied to arm state");
  a_hold_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state == svw_pkg::SVW_RUN) |-> $past(hold_cnt) == hold_limit - ONE)
    else $error("Reset released before hold period");
  a_manual_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == svw_pkg::SVW_RUN && mr_fire && sup_ok) |=> (state == svw_pkg::SVW_HOLD && !armed))
    else $error("Manual reset not honoured");
  a_outputs_comp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reset_out != reset_out_comp) else $error("Reset outputs not complementary");
  a_powerup_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == svw_pkg::SVW_POWERUP && !sup_ok) |=> state == svw_pkg::SVW_POWERUP)
    else $error("Left power-up without supply");
endmodule
`default_nettype wire

//--- verification/svw_host.sv
`timescale 1ns/100ps
`default_nettype none
module svw_host (
  input wire logic clk_sys,
  input wire logic drive_en,
  input wire logic [31:0] period,
  input wire logic strobe_pullup_en,
  output logic pin
);
  logic lvl = 1'b0;
  logic [31:0] cnt = 32'h0;
  // A released pin without pull-up must not look like a clean level
  assign pin = drive_en ? lvl : (strobe_pullup_en ? 1'b1 : ~lvl);
  // First drive is low so that it arms; a period of zero models a stuck program
  always @(posedge clk_sys) begin
    if (!drive_en) begin
      lvl <= 1'b0;
      cnt <= 32'h0;
    end else if (period != 32'h0 && cnt >= period - 32'h1) begin
      lvl <= ~lvl;
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/svw_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module svw_top_bench;
  localparam int WD [4] = '{32'h32, 32'h64, 32'hC8, 32'h190};
  localparam int HLD [4] = '{32'h14, 32'h1E, 32'h28, 32'h3C};
  localparam int MRD = 32'h3;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_good = 1'b0;
  logic manual_reset_in_n = 1'b1;
  logic [1:0] timeout_sel = 2'h0;
  logic [1:0] hold_sel = 2'h0;
  logic drive_en = 1'b0;
  logic [31:0] period = 32'h0;
  wire logic watchdog_strobe_in;
  logic reset_out;
  logic reset_out_comp;
  logic strobe_pullup_en;
  logic armed;
  int num_errors = 0;
  int checked = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  svw_top #(.WD_CYC_0(WD[0]), .WD_CYC_1(WD[1]), .WD_CYC_2(WD[2]), .WD_CYC_3(WD[3]),
    .HOLD_CYC_0(HLD[0]), .HOLD_CYC_1(HLD[1]), .HOLD_CYC_2(HLD[2]), .HOLD_CYC_3(HLD[3]),
    .MRD_CYC(MRD)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .supply_good(supply_good),
    .watchdog_strobe_in(watchdog_strobe_in), .manual_reset_in_n(manual_reset_in_n),
    .timeout_sel(timeout_sel), .hold_sel(hold_sel), .reset_out(reset_out),
    .reset_out_comp(reset_out_comp), .strobe_pullup_en(strobe_pullup_en), .armed(armed));
  svw_host host (.clk_sys(clk_sys), .drive_en(drive_en), .period(period),
    .strobe_pullup_en(strobe_pullup_en), .pin(watchdog_strobe_in));
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Bounded wait on reset_out (which = 0) or armed (which = 1)
  task automatic wait_sig(input bit which, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while ((which ? armed : reset_out) !== lvl && cnt < lim) begin
      @(posedge clk_sys);
      cnt++;
    end
    if ((which ? armed : reset_out) !== lvl) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic start(input int s);
    timeout_sel <= s[1:0];
    hold_sel <= s[1:0];
    drive_en <= 1'b0;
    period <= 32'h0;
    sys_rst <= 1'b1;
    supply_good <= 1'b1;
    repeat (16) @(posedge clk_sys);
    chk({reset_out, reset_out_comp, strobe_pullup_en, armed}, 32'h6);
    sys_rst <= 1'b0;
    wait_sig(0, 1'b1, 200, n);
    chk(n >= HLD[s] && n <= HLD[s] + 8, 32'h1);
    drive_en <= 1'b1;
    wait_sig(1, 1'b1, 10, n);
    chk({strobe_pullup_en, reset_out}, 32'h1);
  endtask
  initial begin
    @(posedge clk_sys);
    for (int r = 0; r < 4; r++) begin
      start(r);
      wait_sig(0, 1'b0, 1000, n);
      chk(n >= WD[r] && n <= WD[r] + 8, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({armed, strobe_pullup_en, reset_out_comp}, 32'h3);
      wait_sig(0, 1'b1, 200, n);
      chk(n >= HLD[r] - 4 && n <= HLD[r] + 4, 32'h1);
      $display("timeout row %0d done", r);
    end
    // Strobe edges every 20 cycles must keep the count from expiring
    start(0);
    period <= 32'h14;
    n = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (reset_out !== 1'b1) n++;
    end
    chk(n, 32'h0);
    $display("strobe test done");
    manual_reset_in_n <= 1'b0;
    wait_sig(0, 1'b0, 12, n);
    manual_reset_in_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({armed, strobe_pullup_en}, 32'h1);
    $display("manual test done");
    // Supply loss must force reset at once and keep it past the hold time
    wait_sig(0, 1'b1, 200, n);
    supply_good <= 1'b0;
    wait_sig(0, 1'b0, 8, n);
    repeat (40) @(posedge clk_sys);
    chk({reset_out, armed, strobe_pullup_en}, 32'h1);
    $display("supply test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
